// ===== pcs_pkg.sv
// Shared constants for the PHY configuration slave port.
// Assumes a single 250 MHz clock shared by both ends.
package pcs_pkg;

  // Configuration: narrow build for 2.5G and 1G/2.5G, wide otherwise
  localparam bit          NARROW_CFG  = 1'b1;
  localparam int unsigned ADDR_W      = NARROW_CFG ? 5 : 11;
  localparam int unsigned RDATA_W     = NARROW_CFG ? 16 : 32;
  localparam int unsigned WDATA_W     = NARROW_CFG ? 16 : 32;
  localparam int unsigned REG_W       = 16;
  localparam int unsigned NUM_REGS    = 1 << ADDR_W;

  // Busy cycles before a request is accepted
  localparam logic [3:0]  ACCEPT_WAIT = 4'h2;
  localparam logic [15:0] REG_RESET   = 16'h0000;

endpackage : pcs_pkg

// ===== pcs_if.sv
// Carrier between the host master and the PHY configuration slave.
// Assumes both ends share the clock that the testbench provides.
`timescale 1ns/10ps
interface pcs_if;
  import pcs_pkg::*;
  logic [ADDR_W-1:0]  address;
  logic               read;
  logic               write;
  logic [WDATA_W-1:0] writedata;
  logic [RDATA_W-1:0] readdata;
  logic               waitrequest;

  modport dev (
    input  address,
    input  read,
    input  write,
    input  writedata,
    output readdata,
    output waitrequest
  );
  modport host (
    output address,
    output read,
    output write,
    output writedata,
    input  readdata,
    input  waitrequest
  );
endinterface : pcs_if

// ===== pcs_slave.sv
// PHY end: word-addressed 16-bit configuration registers behind a
// wait-request slave port. Assumes the host keeps its own rules.
// Operation
// - One address selects one 16-bit register
// - Address bus selects read or write target
// - Host asserts read strobe to read
// - Host asserts write strobe to write
// - Read data valid only while wait-request low
// - Write commits only while wait-request low
// - Wait-request high while busy, low on accept
// - Host holds request while wait-request high
// - Host ignores wait-request in idle and reset
`timescale 1ns/10ps
module pcs_slave
  import pcs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  pcs_if.dev               BUS,
  output logic [REG_W-1:0] REG0_VALUE
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {
    S_IDLE,
    S_BUSY,
    S_DONE
  } pcs_state_type;

  // Request captured at take, so the commit never leans on the host
  typedef struct packed {
    pcs_state_type      state;
    logic [3:0]         cnt;
    logic               wait_req;
    logic               is_write;
    logic [ADDR_W-1:0]  addr;
    logic [REG_W-1:0]   wdata;
    logic [RDATA_W-1:0] rdata;
    logic [REG_W-1:0]   reg0;
  } pcs_dev_type;

  pcs_dev_type      cur;
  pcs_dev_type      next_cur;
  logic [REG_W-1:0] regs [NUM_REGS];
  logic             req_seen;
  logic             commit;
  logic [REG_W-1:0] addr_word;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Either strobe counts; the host keeps them exclusive
  function automatic logic req_any(
    input logic rd,
    input logic wr
  );
    return rd || wr;
  endfunction : req_any

  function automatic logic cnt_last(
    input logic [3:0] c
  );
    return (c <= 4'h1);
  endfunction : cnt_last

  function automatic logic [3:0] cnt_step(
    input logic [3:0] c
  );
    return c - 4'h1;
  endfunction : cnt_step

  // Word widened to the read bus; upper read bits are zero
  function automatic logic [RDATA_W-1:0] to_rdata(
    input logic [REG_W-1:0] w
  );
    return RDATA_W'(w);
  endfunction : to_rdata

  // Registers are 16 bits; wider write bits are dropped
  function automatic logic [REG_W-1:0] to_word(
    input logic [WDATA_W-1:0] d
  );
    return d[REG_W-1:0];
  endfunction : to_word

  ////////////////////////////////////////////////////////////////////////
  // Handshake
  always_comb begin
    req_seen      = req_any(BUS.read, BUS.write);
    addr_word     = regs[cur.addr];
    next_cur      = cur;
    next_cur.reg0 = regs[0];
    commit        = 1'b0;
    unique case (cur.state)
      S_IDLE: begin
        // High while idle, so a fresh strobe is always stalled first
        next_cur.wait_req = 1'b1;
        if (req_seen) begin
          next_cur.state    = S_BUSY;
          next_cur.cnt      = ACCEPT_WAIT;
          next_cur.is_write = BUS.write;
          next_cur.addr     = BUS.address;
          next_cur.wdata    = to_word(BUS.writedata);
        end
      end
      S_BUSY: begin
        next_cur.wait_req = 1'b1;
        if (!cnt_last(cur.cnt)) begin
          next_cur.cnt = cnt_step(cur.cnt);
        end else begin
          next_cur.state    = S_DONE;
          next_cur.cnt      = 4'h0;
          next_cur.wait_req = 1'b0;
          next_cur.rdata    = to_rdata(addr_word);
        end
      end
      S_DONE: begin
        // Accepted cycle: wait-request low, a write lands at its end
        commit            = cur.is_write;
        next_cur.state    = S_IDLE;
        next_cur.wait_req = 1'b1;
      end
      default: begin
        next_cur.state    = S_IDLE;
        next_cur.wait_req = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, one 16-bit word per address
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < int'(NUM_REGS); i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (commit) begin
      regs[cur.addr] <= cur.wdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cur.state    <= S_IDLE;
      cur.cnt      <= 4'h0;
      cur.wait_req <= 1'b1;
      cur.is_write <= 1'b0;
      cur.addr     <= '0;
      cur.wdata    <= REG_RESET;
      cur.rdata    <= '0;
      cur.reg0     <= REG_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign BUS.readdata    = cur.rdata;
  assign BUS.waitrequest = cur.wait_req;
  assign REG0_VALUE      = cur.reg0;

endmodule : pcs_slave

// ===== pcs_master.sv
// Host end: turns one-cycle user commands into a held bus request.
// Assumes the slave answers by dropping wait-request.
`timescale 1ns/10ps
module pcs_master
  import pcs_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RST_B,
  pcs_if.host                     BUS,
  input  wire logic               REQ_VALID,
  input  wire logic               REQ_WRITE,
  input  wire logic [ADDR_W-1:0]  REQ_ADDR,
  input  wire logic [WDATA_W-1:0] REQ_WDATA,
  output logic                    REQ_READY,
  output logic                    RSP_VALID,
  output logic [RDATA_W-1:0]      RSP_DATA
);

  typedef struct packed {
    logic               busy;
    logic               ready;
    logic               rd;
    logic               wr;
    logic [ADDR_W-1:0]  addr;
    logic [WDATA_W-1:0] wdata;
    logic               rsp;
    logic [RDATA_W-1:0] rdata;
  } pcs_host_type;

  pcs_host_type cur;
  pcs_host_type next_cur;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur     = cur;
    next_cur.rsp = 1'b0;
    if (!cur.busy) begin
      // One outstanding request; never read and write together
      if (REQ_VALID) begin
        next_cur.busy  = 1'b1;
        next_cur.ready = 1'b0;
        next_cur.rd    = !REQ_WRITE;
        next_cur.wr    = REQ_WRITE;
        next_cur.addr  = REQ_ADDR;
        next_cur.wdata = REQ_WDATA;
      end
    end else if (!BUS.waitrequest) begin
      next_cur.busy  = 1'b0;
      next_cur.ready = 1'b1;
      next_cur.rd    = 1'b0;
      next_cur.wr    = 1'b0;
      next_cur.rsp   = 1'b1;
      if (cur.rd) begin
        next_cur.rdata = BUS.readdata;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cur.busy  <= 1'b0;
      cur.ready <= 1'b1;
      cur.rd    <= 1'b0;
      cur.wr    <= 1'b0;
      cur.addr  <= '0;
      cur.wdata <= '0;
      cur.rsp   <= 1'b0;
      cur.rdata <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign BUS.read      = cur.rd;
  assign BUS.write     = cur.wr;
  assign BUS.address   = cur.addr;
  assign BUS.writedata = cur.wdata;
  assign REQ_READY     = cur.ready;
  assign RSP_VALID     = cur.rsp;
  assign RSP_DATA      = cur.rdata;

endmodule : pcs_master

// ===== pcs_chk.sv
// Checker on the carrier between host and PHY ends.
// Assumes the bench wires in the carrier signals.
`timescale 1ns/10ps
module pcs_chk
  import pcs_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RST_B,
  input wire logic [ADDR_W-1:0]  address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [WDATA_W-1:0] writedata,
  input wire logic [RDATA_W-1:0] readdata,
  input wire logic               waitrequest
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  sequence s_busy;
    waitrequest [*3];
  endsequence
  sequence s_rel;
    waitrequest && !read && !write;
  endsequence
  AST_WAIT: assert property ($rose(read || write) |->
    s_busy ##1 !waitrequest) else $error("late accept");
  AST_REL: assert property (!waitrequest |=> s_rel)
    else $error("no release");
  AST_IDLE: assert property (!waitrequest |-> read || write)
    else $error("idle accept");
  AST_EXCL: assert property (!(read && write))
    else $error("both strobes");
  AST_ADDR: assert property (waitrequest && (read || write)
    |=> $stable(address)) else $error("address moved");
  AST_HOLD: assert property (waitrequest && (read || write)
    |=> $stable({read, write, writedata})) else $error("request moved");
  // Read data only sampled at accept, so it must not wander
  AST_RDATA: assert property (waitrequest |-> $stable(readdata))
    else $error("readdata moved");
  AST_FALL: assert property ($fell(read || write)
    |-> !$past(waitrequest)) else $error("early release");
endmodule : pcs_chk

// ===== tb_top.sv
// Bench: host and PHY ends joined by the carrier.
// Assumes nothing outside; makes clock and reset.
`timescale 1ns/10ps
module tb_top;
  import pcs_pkg::*;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               v = 1'b0;
  logic               wr = 1'b0;
  logic [ADDR_W-1:0]  ad = '0;
  logic [WDATA_W-1:0] wd = '0;
  logic               rdy;
  logic               rv;
  logic [RDATA_W-1:0] rd;
  logic [REG_W-1:0]   reg0;
  int                 err_total = 0;
  int                 checked = 0;
  int                 cyc = 0;
  pcs_if u_pcs_if ();
  pcs_slave u_pcs_slave (.CLK(clk), .RST_B(rst_b), .BUS(u_pcs_if),
    .REG0_VALUE(reg0));
  pcs_master u_pcs_master (.CLK(clk), .RST_B(rst_b), .BUS(u_pcs_if),
    .REQ_VALID(v), .REQ_WRITE(wr), .REQ_ADDR(ad), .REQ_WDATA(wd),
    .REQ_READY(rdy), .RSP_VALID(rv), .RSP_DATA(rd));
  pcs_chk u_pcs_chk (.CLK(clk), .RST_B(rst_b), .address(u_pcs_if.address),
    .read(u_pcs_if.read), .write(u_pcs_if.write),
    .writedata(u_pcs_if.writedata), .readdata(u_pcs_if.readdata),
    .waitrequest(u_pcs_if.waitrequest));
  always #2 clk = ~clk;
  // Whole run is about 100 cycles; far ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  task automatic op(input logic w, input logic [ADDR_W-1:0] a,
    input logic [WDATA_W-1:0] d, output logic [RDATA_W-1:0] q);
    int n;
    int m;
    n = 0;
    m = 0;
    // Outputs looked at on the falling edge, away from the launch edge
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    v <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    v <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      m += int'(u_pcs_if.read | u_pcs_if.write);
    end while (rv !== 1'b1 && n < 20);
    q = rd;
    cmp("latency", 5, n);
    cmp("strobe cycles", 4, m);
    @(negedge clk);
    cmp("rsp pulse", 0, 32'(rv));
  endtask : op
  ////////////////////////////////////////
  task automatic t_wr;
    logic [RDATA_W-1:0] q;
    for (int i = 0; i < 4; i++) begin
      op(1'b1, ADDR_W'(i * 31 / 3), WDATA_W'(32'h5a00 + i), q);
    end
    for (int i = 0; i < 4; i++) begin
      op(1'b0, ADDR_W'(i * 31 / 3), '0, q);
      cmp("readback", 16'h5a00 + i, 32'(q));
    end
    cmp("reg0", 32'h5a00, 32'(reg0));
  endtask : t_wr
  // Second reset in mid-run must wipe a written register
  task automatic t_rst;
    logic [RDATA_W-1:0] q;
    op(1'b1, 5'h03, 16'h1234, q);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp("ready after reset", 1, 32'(rdy));
    cmp("reg0 after reset", 32'(REG_RESET), 32'(reg0));
    op(1'b0, 5'h03, '0, q);
    cmp("reset value", 32'(REG_RESET), 32'(q));
  endtask : t_rst
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_wr();
    t_rst();
    end_sim();
  end
endmodule : tb_top
